/* design/fpac_top.sv */
// Flash program access controller: tool entry, locks, keyed control
//
// Implementation choice: the APB slave port.
`default_nettype none
// Operation
// - Flash accepts one byte or a group of up to 32 bytes per operation.
// - Erasing one sector leaves all other sectors untouched.
// - Tool sessions may program and erase both sectors and the config row.
// - Self-programming refuses writes and erases to sector 0.
// - Tool enters serial mode by clock pulses while holding reset low.
// - Serial mode boots from the system memory vector, not the normal one.
// - 35-pulse entry runs the device from the external clock input.
// - 38-pulse entry forces main RC if selected, else wake-up RC.
// - RESET returns the serial clock pin to input; the reset pin alone does not.
// - Tool loads a driver byte-wise over serial data; device runs it.
// - Read-out lock and write lock are independent controls.
// - Read-out lock blocks extraction and flash writes.
// - Clearing read-out lock via config row erases program memory first.
// - Write lock refuses all program memory operations until RESET clears it; the mass erase for a config row change under read-out lock still runs.
// - Flash control register resets to zero; bits 7 to 3 read zero.
module fpac_top
  import fpac_pkg::*;
(
  input wire logic REF_CLK, // System clock
  input wire logic RESET, // Sync reset, active high
  input wire fpac_pkg::fpac_apb_req_t APB_REQ, // APB request
  output fpac_pkg::fpac_apb_rsp_t APB_RSP, // APB answer
  input wire logic LINK_CLK, // Serial clock pin, input side
  output logic SCLK_OE, // Serial clock pin drive enable
  output logic SCLK_OUT, // Serial clock pin output level
  input wire logic TOOL_RESET_N, // Reset pin level
  input wire logic TOOL_DATA, // Serial data pin level
  input wire logic CFG_READOUT_LOCK, // Read-out lock option bit
  input wire logic CFG_WRITE_LOCK, // Write lock option bit
  input wire logic CFG_RC_SEL, // Option selects main RC
  output fpac_pkg::fpac_flash_t FLASH, // Flash operation request
  input wire logic FLASH_DONE, // Flash operation finished
  output logic BOOT_FROM_SYSMEM, // Use serial mode reset vector
  output logic [1:0] CLK_SEL, // Forced clock source
  output logic [7:0] RX_BYTE, // Byte received from tool
  output logic RX_VALID // Byte strobe
);
  import fpac_pkg::*;

  typedef struct packed {
    logic [1:0] rst_s;
    logic [1:0] sess_s;
    logic [7:0] gray;
    logic [7:0] shift;
    logic [2:0] bitcnt;
    logic [7:0] byte_hold;
    logic tog;
  } fpac_link_t;

  typedef struct packed {
    logic [1:0] nrst_s;
    logic nrst_d;
    logic [7:0] g1;
    logic [7:0] g2;
    logic [2:0] tg;
    logic [7:0] base;
    logic session;
    logic ext_entry;
    logic [1:0] clk_sel;
    logic [2:0] fcs;
    fpac_key_t key;
    logic [6:0] opcfg;
    logic refused;
    logic wr_lock;
    logic [1:0] pinctl;
    fpac_fsm_t st;
    logic [31:0] prdata;
    logic slverr;
    logic [7:0] rx_byte;
    logic rx_valid;
  } fpac_main_t;

  fpac_link_t l_reg, l_next;
  fpac_main_t m_reg, m_next;
  logic [7:0] lbin;
  logic [7:0] cnt;
  logic [7:0] pulses;
  logic setup, wr;
  logic [5:0] idx;
  logic start;
  logic bad_prog;

  // Link domain: pulse counter and byte receiver
  always_comb
  begin
    l_next = l_reg;
    lbin = fpac_g2b(l_reg.gray) + 8'h01;
    l_next.rst_s = {l_reg.rst_s[0], RESET};
    l_next.sess_s = {l_reg.sess_s[0], m_reg.session};
    // Every rising edge counted; main side takes the difference across reset low
    l_next.gray = lbin ^ (lbin >> 1);
    if (l_reg.sess_s[1])
    begin
      l_next.shift = {l_reg.shift[6:0], TOOL_DATA};
      l_next.bitcnt = l_reg.bitcnt + 3'h1;
      if (l_reg.bitcnt == 3'h7)
      begin
        l_next.byte_hold = {l_reg.shift[6:0], TOOL_DATA};
        l_next.tog = ~l_reg.tog;
      end
    end
    else
    begin
      l_next.bitcnt = 3'h0;
    end
    if (l_reg.rst_s[1])
    begin
      l_next.shift = 8'h00;
      l_next.bitcnt = 3'h0;
      l_next.byte_hold = 8'h00;
      l_next.tog = 1'b0;
      l_next.gray = 8'h00;
      l_next.sess_s = 2'b00;
    end
  end

  always_ff @(posedge LINK_CLK)
  begin
    l_reg <= l_next;
  end

  assign setup = APB_REQ.psel & ~APB_REQ.penable;
  assign wr = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
  assign idx = APB_REQ.paddr[7:2];

  // Main domain
  always_comb
  begin
    m_next = m_reg;
    cnt = fpac_g2b(m_reg.g2);
    pulses = cnt - m_reg.base;
    start = 1'b0;
    bad_prog = 1'b0;
    m_next.nrst_s = {m_reg.nrst_s[0], TOOL_RESET_N};
    m_next.nrst_d = m_reg.nrst_s[1];
    m_next.g1 = l_reg.gray;
    m_next.g2 = m_reg.g1;
    m_next.tg = {m_reg.tg[1], m_reg.tg[0], l_reg.tog};
    m_next.wr_lock = m_reg.wr_lock | CFG_WRITE_LOCK;
    m_next.rx_valid = 1'b0;

    // Entry pattern judged on release of the reset pin
    if (m_reg.nrst_d && !m_reg.nrst_s[1])
    begin
      m_next.base = cnt;
    end
    if (!m_reg.nrst_d && m_reg.nrst_s[1])
    begin
      m_next.session = (pulses == FPAC_ENTRY_EXT) ||
        (pulses == FPAC_ENTRY_OPT);
      m_next.ext_entry = pulses == FPAC_ENTRY_EXT;
    end
    if (!m_next.session)
    begin
      m_next.clk_sel = FPAC_CLK_NORMAL;
    end
    else if (m_next.ext_entry)
    begin
      m_next.clk_sel = FPAC_CLK_EXT;
    end
    else
    begin
      m_next.clk_sel = CFG_RC_SEL ? FPAC_CLK_MAINRC : FPAC_CLK_WAKE;
    end

    if (m_reg.tg[2] != m_reg.tg[1])
    begin
      m_next.rx_byte = l_reg.byte_hold;
      m_next.rx_valid = 1'b1;
    end

    // APB read data captured in the setup cycle
    if (setup)
    begin
      m_next.slverr = APB_REQ.paddr[1:0] != 2'b00;
      m_next.prdata = 32'h0000_0000;
      unique case (idx)
        FPAC_IDX_FCS: m_next.prdata[2:0] = m_reg.fcs;
        FPAC_IDX_OPCFG: m_next.prdata[6:0] = m_reg.opcfg;
        FPAC_IDX_STATUS: m_next.prdata[7:0] = {1'b0, m_reg.wr_lock,
          CFG_READOUT_LOCK, m_reg.key == FPAC_OPEN, m_reg.ext_entry,
          m_reg.session, m_reg.refused, m_reg.st != FPAC_IDLE};
        FPAC_IDX_PINCTL: m_next.prdata[1:0] = m_reg.pinctl;
        default: m_next.slverr = 1'b1;
      endcase
    end

    if (wr && APB_REQ.paddr[1:0] == 2'b00)
    begin
      unique case (idx)
        FPAC_IDX_FCS:
        begin
          if (m_reg.key == FPAC_OPEN)
          begin
            m_next.fcs[FPAC_FCS_ROW] = APB_REQ.pwdata[FPAC_FCS_ROW];
            m_next.fcs[FPAC_FCS_HOLD] = APB_REQ.pwdata[FPAC_FCS_HOLD];
            start = APB_REQ.pwdata[FPAC_FCS_START] &&
              m_reg.st == FPAC_IDLE;
          end
          else if (m_reg.key == FPAC_LOCKED &&
            APB_REQ.pwdata[7:0] == FPAC_KEY1)
          begin
            m_next.key = FPAC_KEY1_SEEN;
          end
          else if (m_reg.key == FPAC_KEY1_SEEN &&
            APB_REQ.pwdata[7:0] == FPAC_KEY2)
          begin
            m_next.key = FPAC_OPEN;
          end
          else
          begin
            m_next.key = FPAC_LOCKED;
          end
        end
        FPAC_IDX_OPCFG:
        begin
          if (m_reg.st == FPAC_IDLE)
          begin
            m_next.opcfg = APB_REQ.pwdata[6:0];
          end
        end
        FPAC_IDX_STATUS:
        begin
          if (APB_REQ.pwdata[FPAC_ST_REFUSED])
          begin
            m_next.refused = 1'b0;
          end
        end
        FPAC_IDX_PINCTL: m_next.pinctl = APB_REQ.pwdata[1:0];
        default: m_next.key = m_reg.key;
      endcase
    end

    // Operation checks; locks are independent of each other
    if (start)
    begin
      bad_prog = !APB_REQ.pwdata[FPAC_FCS_ROW] && (m_next.wr_lock
        || CFG_READOUT_LOCK
        || (!m_reg.session && !m_reg.opcfg[FPAC_OP_SECTOR]));
      if (bad_prog)
      begin
        m_next.refused = 1'b1;
      end
      else
      begin
        m_next.fcs[FPAC_FCS_START] = 1'b1;
        m_next.st = (APB_REQ.pwdata[FPAC_FCS_ROW] && CFG_READOUT_LOCK)
          ? FPAC_MASS : FPAC_OPER;
      end
    end

    unique case (m_reg.st)
      FPAC_IDLE: m_next.st = m_next.st;
      FPAC_MASS:
      begin
        if (FLASH_DONE)
        begin
          m_next.st = FPAC_OPER;
        end
      end
      FPAC_OPER:
      begin
        if (FLASH_DONE)
        begin
          m_next.st = FPAC_IDLE;
          m_next.fcs[FPAC_FCS_START] = 1'b0;
        end
      end
      default: m_next.st = FPAC_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      m_reg <= '0;
      m_reg.nrst_s <= 2'b11; // Pin idles high; no false release edge
      m_reg.nrst_d <= 1'b1;
    end
    else
    begin
      m_reg <= m_next;
    end
  end

  assign APB_RSP.pready = APB_REQ.psel & APB_REQ.penable;
  assign APB_RSP.pslverr = m_reg.slverr & APB_REQ.psel & APB_REQ.penable;
  assign APB_RSP.prdata = m_reg.prdata;
  assign SCLK_OE = m_reg.pinctl[0];
  assign SCLK_OUT = m_reg.pinctl[1];
  assign BOOT_FROM_SYSMEM = m_reg.session;
  assign CLK_SEL = m_reg.clk_sel;
  assign RX_BYTE = m_reg.rx_byte;
  assign RX_VALID = m_reg.rx_valid;
  assign FLASH.req = m_reg.st != FPAC_IDLE;
  assign FLASH.cmd = m_reg.st == FPAC_MASS ? FPAC_CMD_MASS :
    (m_reg.opcfg[FPAC_OP_ERASE] ? FPAC_CMD_ERASE : FPAC_CMD_PROG);
  assign FLASH.row = m_reg.fcs[FPAC_FCS_ROW];
  assign FLASH.sector = m_reg.opcfg[FPAC_OP_SECTOR];
  assign FLASH.count = m_reg.opcfg[6:FPAC_OP_CNT_LSB];
  assign FLASH.hold = m_reg.fcs[FPAC_FCS_HOLD];

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  a_write_lock_refuse: assert property (start && m_next.wr_lock &&
    !APB_REQ.pwdata[FPAC_FCS_ROW] |=> m_reg.refused && !FLASH.req)
    else $error("write lock did not refuse program memory operation");

  a_sector0_selfprog: assert property (start && !m_reg.session &&
    !m_reg.opcfg[FPAC_OP_SECTOR] && !APB_REQ.pwdata[FPAC_FCS_ROW]
    |=> !FLASH.req ##1 !FLASH.req)
    else $error("sector zero touched during self-programming");

  a_readout_block: assert property (FLASH.req && !FLASH.row &&
    FLASH.cmd != FPAC_CMD_MASS |-> !$past(CFG_READOUT_LOCK) ||
    $past(FLASH.req))
    else $error("program memory write started under read-out lock");

  a_mass_first: assert property (start && !bad_prog &&
    APB_REQ.pwdata[FPAC_FCS_ROW] && CFG_READOUT_LOCK
    |=> FLASH.req && FLASH.cmd == FPAC_CMD_MASS)
    else $error("config row change under read-out lock skipped mass erase");

  a_fcs_reset: assert property (disable iff (1'b0)
    RESET |=> m_reg.fcs == FPAC_FCS_RESET && m_reg.prdata[31:3] == '0)
    else $error("flash control register not zero after reset");

  a_key_gate: assert property (wr && idx == FPAC_IDX_FCS &&
    m_reg.key != FPAC_OPEN |=> $stable(m_reg.fcs) && !FLASH.req ||
    $past(FLASH.req))
    else $error("control bits changed without unlock keys");

  a_sclk_input: assert property (disable iff (1'b0)
    RESET |=> !SCLK_OE)
    else $error("serial clock pin still driven after reset");

  a_entry_clock: assert property (m_reg.session && m_reg.ext_entry
    |-> CLK_SEL == FPAC_CLK_EXT && BOOT_FROM_SYSMEM)
    else $error("external clock entry not honoured");

  a_rc_forced: assert property (m_reg.session && !m_reg.ext_entry
    |-> CLK_SEL == (CFG_RC_SEL ? FPAC_CLK_MAINRC : FPAC_CLK_WAKE) ||
    $changed(CFG_RC_SEL))
    else $error("wrong internal oscillator forced in option entry");

  a_sector_steady: assert property (FLASH.req && $past(FLASH.req)
    |-> $stable(FLASH.sector) && $stable(FLASH.count))
    else $error("target sector changed during an operation");

  a_byte_strobe: assert property (RX_VALID |=> !RX_VALID)
    else $error("received byte strobe longer than one cycle");

  a_readout_refuse: assert property (start && CFG_READOUT_LOCK &&
    !APB_REQ.pwdata[FPAC_FCS_ROW] |=> m_reg.refused && !FLASH.req)
    else $error("read-out lock did not refuse program memory write");

  a_tool_access: assert property (start && m_reg.session &&
    !m_next.wr_lock && !CFG_READOUT_LOCK |=> FLASH.req)
    else $error("tool session refused an unlocked operation");
endmodule // fpac_top
`default_nettype wire

/* design/fpac_pkg.sv */
// Package for the flash program access controller
`default_nettype none
package fpac_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] FPAC_IDX_FCS = 6'h2f;
  localparam logic [5:0] FPAC_IDX_OPCFG = 6'h30;
  localparam logic [5:0] FPAC_IDX_STATUS = 6'h31;
  localparam logic [5:0] FPAC_IDX_PINCTL = 6'h32;
  localparam logic [2:0] FPAC_FCS_RESET = 3'h0;
  localparam int FPAC_FCS_ROW = 2;
  localparam int FPAC_FCS_HOLD = 1;
  localparam int FPAC_FCS_START = 0;
  localparam logic [7:0] FPAC_KEY1 = 8'h56;
  localparam logic [7:0] FPAC_KEY2 = 8'hae;
  localparam int FPAC_OP_ERASE = 0;
  localparam int FPAC_OP_SECTOR = 1;
  localparam int FPAC_OP_CNT_LSB = 2;
  localparam int FPAC_ST_REFUSED = 1;
  localparam logic [7:0] FPAC_ENTRY_EXT = 8'h23;
  localparam logic [7:0] FPAC_ENTRY_OPT = 8'h26;
  localparam logic [1:0] FPAC_CLK_NORMAL = 2'h0;
  localparam logic [1:0] FPAC_CLK_EXT = 2'h1;
  localparam logic [1:0] FPAC_CLK_MAINRC = 2'h2;
  localparam logic [1:0] FPAC_CLK_WAKE = 2'h3;

  typedef enum logic [1:0] {FPAC_IDLE = 2'b00, FPAC_OPER = 2'b01,
    FPAC_MASS = 2'b11} fpac_fsm_t;
  typedef enum logic [1:0] {FPAC_LOCKED = 2'b00, FPAC_KEY1_SEEN = 2'b01,
    FPAC_OPEN = 2'b11} fpac_key_t;
  typedef enum logic [1:0] {FPAC_CMD_PROG = 2'h0, FPAC_CMD_ERASE = 2'h1,
    FPAC_CMD_MASS = 2'h2} fpac_cmd_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fpac_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fpac_apb_rsp_t;
  typedef struct packed {
    logic req;
    fpac_cmd_t cmd;
    logic row;
    logic sector;
    logic [4:0] count;
    logic hold;
  } fpac_flash_t;

  function automatic logic [7:0] fpac_g2b(input logic [7:0] g);
    logic [7:0] b;
    b[7] = g[7];
    for (int i = 6; i >= 0; i--)
    begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction
endpackage
`default_nettype wire

/* testbench/fpac_tool.sv */
// Model of the external programming tool on the serial link
`default_nettype none
module fpac_tool (
  output logic link_clk, // Serial clock pin, idles high
  output logic reset_n, // Reset pin, owned by the tool
  output logic data // Serial data pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    link_clk = 1'b1;
    reset_n = 1'b1;
    data = 1'b1;
  end
  // Clock pulses of 12 ns; clock stands still otherwise
  task automatic pulse(input int n);
    repeat (n)
    begin
      link_clk = 1'b0;
      #6;
      link_clk = 1'b1;
      #6;
    end
  endtask
  // Entry pattern while reset pin held low, with gaps at the edges
  task automatic enter(input int n);
    reset_n = 1'b0;
    #100;
    pulse(n);
    #100;
    reset_n = 1'b1;
    #100;
  endtask
  // One byte MSB first, data set up ahead of each rising edge
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      data = b[i];
      #3;
      link_clk = 1'b0;
      #6;
      link_clk = 1'b1;
      #3;
    end
    data = ~b[0]; // Line no longer shows the last bit
  endtask
endmodule // fpac_tool
`default_nettype wire

/* testbench/test_flash_program_access_control.sv */
// Self-checking bench for the flash program access controller
`default_nettype none
module test_flash_program_access_control;
  import fpac_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] a_fcs = {FPAC_IDX_FCS, 2'b00};
  localparam logic [7:0] a_op = {FPAC_IDX_OPCFG, 2'b00};
  localparam logic [7:0] a_st = {FPAC_IDX_STATUS, 2'b00};
  localparam logic [7:0] a_pin = {FPAC_IDX_PINCTL, 2'b00};
  logic ref_clk, reset, cfg_rd, cfg_wr, cfg_rc, fdone, er, e;
  logic sclk_oe, sclk_out, boot, rx_valid;
  logic [1:0] clk_sel;
  logic [7:0] rx_byte;
  logic [4:0] n;
  logic [31:0] rd, v;
  wire link_clk, tool_rst_n, tool_data;
  fpac_apb_req_t req;
  fpac_apb_rsp_t rsp;
  fpac_flash_t fl;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int k;
  integer seed = 32'h71335cad;

  fpac_top fpac_top_i (.REF_CLK(ref_clk), .RESET(reset), .APB_REQ(req),
    .APB_RSP(rsp), .LINK_CLK(link_clk), .SCLK_OE(sclk_oe),
    .SCLK_OUT(sclk_out), .TOOL_RESET_N(tool_rst_n), .TOOL_DATA(tool_data),
    .CFG_READOUT_LOCK(cfg_rd), .CFG_WRITE_LOCK(cfg_wr),
    .CFG_RC_SEL(cfg_rc), .FLASH(fl), .FLASH_DONE(fdone),
    .BOOT_FROM_SYSMEM(boot), .CLK_SEL(clk_sel), .RX_BYTE(rx_byte),
    .RX_VALID(rx_valid));
  fpac_tool fpac_tool_i (.link_clk(link_clk), .reset_n(tool_rst_n),
    .data(tool_data));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input string s, input logic [31:0] x,
    input logic [31:0] g);
    cmp_count++;
    if (g !== x)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask

  // One transfer; held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic unlock();
    wr(a_fcs, 32'(FPAC_KEY1));
    wr(a_fcs, 32'(FPAC_KEY2));
  endtask

  task automatic op(input logic [31:0] cfg, input logic [31:0] f);
    wr(a_op, cfg);
    wr(a_fcs, f);
  endtask

  // Flash side: check one step, answer after a random delay
  task automatic fstep(input fpac_cmd_t c, input logic row, sec,
    input logic [4:0] cnt);
    k = 0;
    while (fl.req !== 1'b1 && k < 50)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk("flash req", 1, fl.req);
    chk("flash cmd", c, fl.cmd);
    chk("flash row", row, fl.row);
    chk("flash sector", sec, fl.sector);
    chk("flash count", cnt, fl.count);
    repeat ($random(seed) & 7) @(posedge ref_clk);
    fdone <= 1'b1;
    @(posedge ref_clk);
    fdone <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic refused();
    @(posedge ref_clk);
    chk("flash req", 0, fl.req);
    rdr(a_st);
    chk("refused", 1, rd[FPAC_ST_REFUSED]);
    wr(a_st, 32'h2);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    fpac_tool_i.pulse(4);
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    fpac_tool_i.pulse(2); // Link side leaves reset only on its own clock
  endtask

  initial
  begin
    req = '0;
    {fdone, cfg_rd, cfg_wr, cfg_rc} = 4'h0;
    reset = 1'b1;
    do_reset();
    rdr(a_fcs);
    chk("fcs reset", 0, rd);
    rdr(8'h04);
    chk("unmapped", 1, er);
    wr(a_fcs, 32'h7);
    rdr(a_fcs);
    chk("fcs locked", 0, rd);
    wr(a_fcs, 32'(FPAC_KEY2));
    wr(a_fcs, 32'(FPAC_KEY1));
    wr(a_fcs, 32'h4);
    rdr(a_fcs);
    chk("fcs order", 0, rd);
    unlock();
    wr(a_fcs, 32'hfc);
    rdr(a_fcs);
    chk("fcs bits", 32'h4, rd);
    wr(a_fcs, 32'h2);
    @(posedge ref_clk);
    chk("flash hold", 1, fl.hold);
    wr(a_fcs, 32'h0);
    $display("Test registers finished");
    for (int i = 0; i < 4; i++)
    begin
      n = (i == 0) ? 5'd0 : (i == 1) ? 5'd31 : 5'($random(seed));
      e = (i < 2) ? 1'(i) : 1'($random(seed));
      op({25'h0, n, 1'b1, e}, 32'h1);
      fstep(e ? FPAC_CMD_ERASE : FPAC_CMD_PROG, 0, 1, n);
      rdr(a_fcs);
      chk("start clear", 0, rd);
    end
    op(32'h0, 32'h1);
    refused();
    rdr(a_st);
    chk("refused clear", 0, rd[FPAC_ST_REFUSED]);
    $display("Test operations finished");
    cfg_rd <= 1'b1;
    op(32'h2, 32'h1);
    refused();
    rdr(a_st);
    chk("lock bits", 2'b01, rd[6:5]);
    wr(a_fcs, 32'h5);
    fstep(FPAC_CMD_MASS, 1, 1, 0);
    fstep(FPAC_CMD_PROG, 1, 1, 0);
    cfg_rd <= 1'b0;
    cfg_wr <= 1'b1;
    repeat (2) @(posedge ref_clk);
    cfg_wr <= 1'b0;
    op(32'h2, 32'h1);
    refused();
    rdr(a_st);
    chk("lock bits", 2'b10, rd[6:5]);
    wr(a_pin, 32'h3);
    @(posedge ref_clk);
    chk("sclk oe", 1, sclk_oe);
    chk("sclk out", 1, sclk_out);
    do_reset();
    @(posedge ref_clk);
    chk("sclk oe", 0, sclk_oe);
    $display("Test locks finished");
    fpac_tool_i.enter(35);
    repeat (6) @(posedge ref_clk);
    chk("boot", 1, boot);
    chk("clk sel", FPAC_CLK_EXT, clk_sel);
    fpac_tool_i.pulse(2);
    v = $random(seed);
    fpac_tool_i.send(v[7:0]);
    k = 0;
    while (rx_valid !== 1'b1 && k < 20)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk("rx valid", 1, rx_valid);
    chk("rx byte", v[7:0], rx_byte);
    unlock();
    op(32'h0, 32'h1);
    fstep(FPAC_CMD_PROG, 0, 0, 0);
    for (int r = 0; r < 2; r++)
    begin
      cfg_rc <= r[0];
      fpac_tool_i.enter(38);
      repeat (6) @(posedge ref_clk);
      chk("clk sel", r ? FPAC_CLK_MAINRC : FPAC_CLK_WAKE, clk_sel);
    end
    fpac_tool_i.enter(30);
    repeat (6) @(posedge ref_clk);
    chk("boot", 0, boot);
    $display("Test entry finished");
    end_sim();
  end
endmodule // test_flash_program_access_control
`default_nettype wire
